// *** hdl/vdcs_regs.sv ***
// Purpose: control/status register bank of one video decoder channel
// Assumes: serial host engine delivers single-cycle rd/wr strobes on ref_clk_i;
//          decoder core inputs are already on ref_clk_i
// Notes:   read data is registered and valid one cycle after the rd strobe
module vdcs_regs
    import vdcs_pkg::*;
#(
    parameter logic [15:0] PART_CODE = PART_CODE_DEF,  // arbitrary value
    parameter logic [7:0]  FW_MAJOR  = FW_MAJOR_DEF,   // arbitrary value
    parameter logic [7:0]  FW_MINOR  = FW_MINOR_DEF    // arbitrary value
) (
    input  wire logic                ref_clk_i,        // 100 MHz system clock
    input  wire logic                reset_n_i,        // async reset, active low
    input  wire vdcs_req_type        req_i,            // register access request
    output logic       [DATA_W-1:0]  rdata_o,          // read data, registered
    output logic                     rvalid_o,         // read data valid pulse
    input  wire logic  [DATA_W-1:0]  blue_gain_i,      // applied blue chroma gain
    input  wire logic  [DATA_W-1:0]  red_gain_i,       // applied red chroma gain
    input  wire logic  [LINE_W-1:0]  line_count_i,     // detected lines per frame
    input  wire vdcs_cond_type       cond_i,           // detected conditions
    input  wire logic                init_done_i,      // software init complete
    input  wire logic                cmd_ready_i,      // core can take a command
    output logic                     autoswitch_o,     // automatic detection on
    output logic       [STD_W-1:0]   forced_std_o,     // forced standard code
    output logic signed [CROP_W-1:0] crop_stop_o,      // active window stop offset
    output logic                     crop_load_o,      // crop stop update pulse
    output logic                     timing_rev_o,     // 1: older sync timing
    output logic                     event_irq_o       // enabled event pending
);

    // address decode
    logic wr_std, wr_crop_hi, wr_crop_lo, wr_rev, wr_clear, wr_enable;
    assign wr_std     = req_i.wr && (req_i.addr == OFS_STD_SELECT);
    assign wr_crop_hi = req_i.wr && (req_i.addr == OFS_CROP_HIGH);
    assign wr_crop_lo = req_i.wr && (req_i.addr == OFS_CROP_LOW);
    assign wr_rev     = req_i.wr && (req_i.addr == OFS_TIMING_REV);
    assign wr_clear   = req_i.wr && (req_i.addr == OFS_EVENT_CLEAR);
    assign wr_enable  = req_i.wr && (req_i.addr == OFS_EVENT_ENABLE);

    // a standard code is legal when even and not beyond the last one
    function automatic logic std_legal(input logic [STD_W-1:0] code);
        std_legal = (code[0] == 1'b0) && (code <= STD_LAST);
    endfunction : std_legal

    logic std_accept;
    assign std_accept = wr_std && std_legal(req_i.wdata[STD_W-1:0]);

    // writable registers
    logic [STD_W-1:0]        std_ff;
    logic [DATA_W-1:0]       crop_stage_ff;
    logic [CROP_LOW_W-1:0]   crop_low_ff;
    logic [CROP_W-1:0]       crop_stop_ff;
    logic                    crop_load_ff;
    logic                    rev_ff;
    logic [DATA_W-1:0]       enable_ff;

    // standard select: illegal codes are dropped so the core never sees them
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            std_ff <= RST_STD;
        end else if (std_accept) begin
            std_ff <= req_i.wdata[STD_W-1:0];
        end
    end

    // high byte is only staged; the window keeps its old stop until low write
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            crop_stage_ff <= RST_BYTE;
        end else if (wr_crop_hi) begin
            crop_stage_ff <= req_i.wdata;
        end
    end

    logic [CROP_W-1:0] nxt_crop_stop;
    assign nxt_crop_stop = {crop_stage_ff, req_i.wdata[CROP_LOW_W-1:0]};

    // low write commits both halves in one cycle
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            crop_low_ff  <= '0;
            crop_stop_ff <= RST_CROP;
            crop_load_ff <= 1'b0;
        end else begin
            crop_load_ff <= wr_crop_lo;
            if (wr_crop_lo) begin
                crop_low_ff  <= req_i.wdata[CROP_LOW_W-1:0];
                crop_stop_ff <= nxt_crop_stop;
            end
        end
    end

    // timing revision and interrupt enable mask
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rev_ff    <= 1'b0;
            enable_ff <= RST_BYTE;
        end else begin
            if (wr_rev) begin
                rev_ff <= req_i.wdata[REV_BIT];
            end
            if (wr_enable) begin
                enable_ff <= req_i.wdata & EV_STICKY;
            end
        end
    end

    // change detection; first cycle after reset only primes the history so
    // conditions already high at reset do not look like toggles
    vdcs_cond_type cond_prev_ff;
    logic          primed_ff;
    logic          init_prev_ff;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cond_prev_ff <= '0;
            primed_ff    <= 1'b0;
            init_prev_ff <= 1'b0;
        end else begin
            cond_prev_ff <= cond_i;
            primed_ff    <= 1'b1;
            init_prev_ff <= init_done_i;
        end
    end

    vdcs_cond_type cond_toggle;
    assign cond_toggle = primed_ff ? (cond_i ^ cond_prev_ff) : '0;

    logic [DATA_W-1:0] ev_set;
    assign ev_set = {init_done_i & ~init_prev_ff,
                     1'b0,
                     1'b0,
                     cond_toggle.field_rate,
                     cond_toggle.line_alt,
                     cond_toggle.color_lock,
                     cond_toggle.sync_lock,
                     cond_toggle.source_kind};

    logic [DATA_W-1:0] ev_clr;
    assign ev_clr = wr_clear ? (req_i.wdata & EV_STICKY) : '0;

    // sticky flags: a set in the clearing cycle wins; the mask plays no part
    logic [DATA_W-1:0] flags_ff;
    logic [DATA_W-1:0] nxt_flags;
    assign nxt_flags = ((flags_ff & ~ev_clr) | ev_set) & EV_STICKY;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_ff <= RST_BYTE;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // command-ready is a live level: it cannot read set while the core is busy
    logic [DATA_W-1:0] status_view;
    assign status_view = (flags_ff | ({{(DATA_W-1){1'b0}}, cmd_ready_i} << EV_CMD_READY))
                         & EV_MASK;

    // read mux; unmapped subaddresses and write-only clear read as zero
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        unique case (req_i.addr)
            OFS_STD_SELECT:   rd_mux = {{(DATA_W-STD_W){1'b0}}, std_ff};
            OFS_CROP_HIGH:    rd_mux = crop_stage_ff;
            OFS_CROP_LOW:     rd_mux = {{(DATA_W-CROP_LOW_W){1'b0}}, crop_low_ff};
            OFS_BLUE_GAIN:    rd_mux = blue_gain_i;
            OFS_RED_GAIN:     rd_mux = red_gain_i;
            OFS_TIMING_REV:   rd_mux = {{(DATA_W-1){1'b0}}, rev_ff};
            OFS_EVENT_ENABLE: rd_mux = enable_ff;
            OFS_PART_HIGH:    rd_mux = PART_CODE[15:8];
            OFS_PART_LOW:     rd_mux = PART_CODE[7:0];
            OFS_FW_MAJOR:     rd_mux = FW_MAJOR;
            OFS_FW_MINOR:     rd_mux = FW_MINOR;
            OFS_LINES_HIGH:   rd_mux = {{(DATA_W-LINE_HI_W){1'b0}},
                                        line_count_i[LINE_W-1:DATA_W]};
            OFS_LINES_LOW:    rd_mux = line_count_i[DATA_W-1:0];
            OFS_EVENT_FLAGS:  rd_mux = status_view;
            default:          rd_mux = '0;
        endcase
    end

    // read data held until the next read so a slow serial engine can shift it
    logic [DATA_W-1:0] rdata_ff;
    logic              rvalid_ff;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_ff  <= RST_BYTE;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= req_i.rd;
            if (req_i.rd) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // outputs; read-only registers have no write path at all
    assign rdata_o      = rdata_ff;
    assign rvalid_o     = rvalid_ff;
    assign autoswitch_o = (std_ff == STD_AUTO);
    assign forced_std_o = std_ff;
    assign crop_stop_o  = crop_stop_ff;
    assign crop_load_o  = crop_load_ff;
    assign timing_rev_o = rev_ff;
    assign event_irq_o  = |(flags_ff & enable_ff);

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence crop_hi_seq;
        wr_crop_hi && !wr_crop_lo;
    endsequence

    sequence crop_lo_seq;
        wr_crop_lo;
    endsequence

    std_force_a: assert property (std_accept |=> forced_std_o == $past(req_i.wdata[STD_W-1:0])
                                  && autoswitch_o == ($past(req_i.wdata[STD_W-1:0]) == STD_AUTO))
        else $error("standard write not applied");

    std_reject_a: assert property (wr_std && !std_legal(req_i.wdata[STD_W-1:0])
                                   |=> $stable(forced_std_o))
        else $error("illegal standard code accepted");

    crop_hold_a: assert property (crop_hi_seq |=> $stable(crop_stop_o) && !crop_load_o)
        else $error("crop stop moved on high write");

    crop_apply_a: assert property (crop_lo_seq |=> crop_load_o
                                   && crop_stop_o == $past(nxt_crop_stop))
        else $error("crop stop not applied on low write");

    crop_quiet_a: assert property (!wr_crop_lo |=> $stable(crop_stop_o))
        else $error("crop stop changed without low write");

    flag_set_a: assert property (cond_toggle.color_lock |=> flags_ff[EV_COLOR_LOCK])
        else $error("change flag not set on toggle");

    flag_hold_a: assert property (flags_ff[EV_SYNC_LOCK] && !(wr_clear && req_i.wdata[EV_SYNC_LOCK])
                                  |=> flags_ff[EV_SYNC_LOCK])
        else $error("flag dropped without clear");

    flag_clear_a: assert property (wr_clear && req_i.wdata[EV_SOURCE] && !ev_set[EV_SOURCE]
                                   |=> !flags_ff[EV_SOURCE])
        else $error("flag not cleared by host");

    cmd_live_a: assert property (req_i.rd && req_i.addr == OFS_EVENT_FLAGS
                                 |=> rvalid_o && rdata_o[EV_CMD_READY] == $past(cmd_ready_i)
                                     && !rdata_o[6])
        else $error("status read wrong");

    lines_read_a: assert property (req_i.rd && req_i.addr == OFS_LINES_HIGH
                                   |=> rdata_o == {6'h00, $past(line_count_i[9:8])})
        else $error("line count high wrong");

    irq_gate_a: assert property (|(ev_set & enable_ff & EV_STICKY) && !wr_enable
                                 |=> event_irq_o)
        else $error("enabled event did not raise interrupt");

    id_read_a: assert property (req_i.rd && req_i.addr == OFS_PART_HIGH
                                |=> rdata_o == PART_CODE[15:8] ##1 rdata_o == $past(rdata_o)
                                    || $past(req_i.rd))
        else $error("part code read wrong");

endmodule : vdcs_regs

// *** inc/vdcs_pkg.sv ***
// Purpose: shared constants and carriers for the decoder control/status bank
// Assumes: byte-wide register port, one 100 MHz clock
// Notes:   offsets are byte subaddresses seen by the serial host interface
package vdcs_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CROP_W = 10;
    localparam int unsigned LINE_W = 10;
    localparam int unsigned STD_W  = 4;

    // register subaddresses
    localparam logic [7:0] OFS_EVENT_CLEAR  = 8'h1c;
    localparam logic [7:0] OFS_EVENT_ENABLE = 8'h1d;
    localparam logic [7:0] OFS_STD_SELECT   = 8'h28;
    localparam logic [7:0] OFS_CROP_HIGH    = 8'h29;
    localparam logic [7:0] OFS_CROP_LOW     = 8'h2a;
    localparam logic [7:0] OFS_BLUE_GAIN    = 8'h2c;
    localparam logic [7:0] OFS_RED_GAIN     = 8'h2d;
    localparam logic [7:0] OFS_TIMING_REV   = 8'h30;
    localparam logic [7:0] OFS_PART_HIGH    = 8'h80;
    localparam logic [7:0] OFS_PART_LOW     = 8'h81;
    localparam logic [7:0] OFS_FW_MAJOR     = 8'h82;
    localparam logic [7:0] OFS_FW_MINOR     = 8'h83;
    localparam logic [7:0] OFS_LINES_HIGH   = 8'h84;
    localparam logic [7:0] OFS_LINES_LOW    = 8'h85;
    localparam logic [7:0] OFS_EVENT_FLAGS  = 8'h86;

    // reset values
    localparam logic [7:0]        RST_BYTE = 8'h00;
    localparam logic [STD_W-1:0]  RST_STD  = 4'h0;
    localparam logic [CROP_W-1:0] RST_CROP = 10'h000;

    // event flag bit positions (bit 6 reserved)
    localparam int unsigned EV_INIT_READY = 7;
    localparam int unsigned EV_CMD_READY  = 5;
    localparam int unsigned EV_FIELD_RATE = 4;
    localparam int unsigned EV_LINE_ALT   = 3;
    localparam int unsigned EV_COLOR_LOCK = 2;
    localparam int unsigned EV_SYNC_LOCK  = 1;
    localparam int unsigned EV_SOURCE     = 0;
    localparam logic [7:0]  EV_MASK       = 8'hbf;   // flag bits visible on a status read
    localparam logic [7:0]  EV_STICKY     = 8'h9f;   // flags cleared by host

    // field widths and positions inside byte registers
    localparam int unsigned CROP_LOW_W = 2;
    localparam int unsigned LINE_HI_W  = 2;
    localparam int unsigned REV_BIT    = 0;

    // standard-select codes
    localparam logic [STD_W-1:0] STD_AUTO  = 4'h0;
    localparam logic [STD_W-1:0] STD_LAST  = 4'hc;

    // identity values; arbitrary neutral values
    localparam logic [15:0] PART_CODE_DEF = 16'ha5c3;
    localparam logic [7:0]  FW_MAJOR_DEF  = 8'h01;
    localparam logic [7:0]  FW_MINOR_DEF  = 8'h01;

    // detected conditions from the decoder core, one bit each
    typedef struct packed {
        logic field_rate;
        logic line_alt;
        logic color_lock;
        logic sync_lock;
        logic source_kind;
    } vdcs_cond_type;

    // register port request from the serial host engine
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } vdcs_req_type;

endpackage : vdcs_pkg

// *** testbench/tb_video_decoder_control_status_regs.sv ***
// Purpose: self-checking bench for the decoder control/status bank
// Assumes: host model drives requests; reads are checked from a queue
// Notes:   identity parameters are overridden with arbitrary values
module tb_video_decoder_control_status_regs;
    import vdcs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] PART_T = 16'h3c96;  // arbitrary value
    localparam logic [7:0]  MAJ_T  = 8'h07;     // arbitrary value
    localparam logic [7:0]  MIN_T  = 8'h2e;     // arbitrary value

    logic ref_clk, reset_n, rvalid, init_done, cmd_ready, autoswitch, crop_load;
    logic timing_rev, event_irq;
    logic [7:0] rdata, blue_gain, red_gain;
    logic [9:0] line_count;
    logic [3:0] forced_std;
    logic signed [9:0] crop_stop;
    vdcs_req_type  req;
    vdcs_cond_type cond;
    logic [7:0] exp_q[$], adr_q[$];
    int fail_count = 0;
    int comparisons = 0;

    vdcs_host_model host (.ref_clk_i(ref_clk), .req_o(req));

    vdcs_regs #(.PART_CODE(PART_T), .FW_MAJOR(MAJ_T), .FW_MINOR(MIN_T)) uut (
        .ref_clk_i(ref_clk), .reset_n_i(reset_n), .req_i(req), .rdata_o(rdata),
        .rvalid_o(rvalid), .blue_gain_i(blue_gain), .red_gain_i(red_gain),
        .line_count_i(line_count), .cond_i(cond), .init_done_i(init_done),
        .cmd_ready_i(cmd_ready), .autoswitch_o(autoswitch), .forced_std_o(forced_std),
        .crop_stop_o(crop_stop), .crop_load_o(crop_load), .timing_rev_o(timing_rev),
        .event_irq_o(event_irq));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check_out(input string nm, input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check_out

    task automatic check_read(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED read %h expected %h seen %h", a, exp, got);
        end
    endtask : check_read

    // the read note goes on the queue before the answer can appear
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        adr_q.push_back(a);
        host.read_reg(a);
    endtask : rd_chk

    task automatic results;
        if (exp_q.size() != 0) fail_count++;
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // every read answer is matched against the oldest note
    always @(negedge ref_clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("CHECK FAILED read unexpected expected none seen %h", rdata);
            end else begin
                check_read(adr_q.pop_front(), exp_q.pop_front(), rdata);
            end
        end
    end

    // cut a hang short; the full run needs well under a thousand cycles
    initial begin
        #50000;
        fail_count++;
        results();
    end

    initial begin
        int i;
        logic [7:0] h, l, v;
        logic [3:0] prev;
        reset_n = 1'b0;
        blue_gain = 8'h00;
        red_gain = 8'h00;
        line_count = 10'h000;
        cond = '0;
        init_done = 1'b0;
        cmd_ready = 1'b0;
        void'($urandom(92357));
        repeat (6) @(negedge ref_clk);
        reset_n = 1'b1;
        check_out("autoswitch", 10'(autoswitch), 10'h001);
        check_out("crop_stop", crop_stop, 10'h000);
        check_out("event_irq", 10'(event_irq), 10'h000);
        rd_chk(OFS_CROP_HIGH, 8'h00);
        rd_chk(OFS_TIMING_REV, 8'h00);
        rd_chk(OFS_EVENT_FLAGS, 8'h00);
        // fixed and live read-only bytes, then overwrite attempts and a re-read
        for (i = 0; i < 2; i++) begin
            @(negedge ref_clk);
            blue_gain = 8'($urandom);
            red_gain = 8'($urandom);
            line_count = 10'($urandom);
            rd_chk(OFS_PART_HIGH, PART_T[15:8]);
            rd_chk(OFS_PART_LOW, PART_T[7:0]);
            rd_chk(OFS_FW_MAJOR, MAJ_T);
            rd_chk(OFS_FW_MINOR, MIN_T);
            rd_chk(OFS_BLUE_GAIN, blue_gain);
            rd_chk(OFS_RED_GAIN, red_gain);
            rd_chk(OFS_LINES_HIGH, {6'h00, line_count[9:8]});
            rd_chk(OFS_LINES_LOW, line_count[7:0]);
            for (v = OFS_PART_HIGH; v <= OFS_EVENT_FLAGS; v++) begin
                host.write_reg(v, 8'hff);
            end
            host.write_reg(OFS_BLUE_GAIN, ~blue_gain);
            host.write_reg(OFS_RED_GAIN, ~red_gain);
        end
        rd_chk(OFS_EVENT_FLAGS, 8'h00);
        rd_chk(8'h55, 8'h00);
        // timing revision: only bit 0 is kept
        for (i = 0; i < 2; i++) begin
            host.write_reg(OFS_TIMING_REV, i ? 8'hfe : 8'hff);
            check_out("timing_rev", 10'(timing_rev), i ? 10'h0 : 10'h1);
            rd_chk(OFS_TIMING_REV, i ? 8'h00 : 8'h01);
        end
        // every standard code; odd and beyond-last codes leave the old one
        prev = STD_AUTO;
        for (i = 0; i < 16; i++) begin
            host.write_reg(OFS_STD_SELECT, 8'(i));
            if (i[0] == 1'b0 && i <= int'(STD_LAST)) prev = 4'(i);
            check_out("forced_std", 10'(forced_std), 10'(prev));
            check_out("autoswitch", 10'(autoswitch), 10'(prev == STD_AUTO));
            rd_chk(OFS_STD_SELECT, {4'h0, prev});
        end
        // crop stop: extreme high bytes then random, high byte staged until low write
        for (i = 0; i < 3; i++) begin
            h = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($urandom);
            l = 8'($urandom) & 8'hfe;
            v = crop_stop[9:2];
            host.write_reg(OFS_CROP_HIGH, h);
            check_out("crop_stop", crop_stop[9:2], 10'(v));
            check_out("crop_load", 10'(crop_load), 10'h0);
            host.write_reg(OFS_CROP_LOW, l);
            check_out("crop_stop", crop_stop, {h, l[1:0]});
            check_out("crop_load", 10'(crop_load), 10'h1);
            rd_chk(OFS_CROP_HIGH, h);
            rd_chk(OFS_CROP_LOW, {6'h00, l[1:0]});
            check_out("crop_load", 10'(crop_load), 10'h0);
        end
        // flags with the interrupt mask closed, then sticky clear
        @(negedge ref_clk);
        init_done = 1'b1;
        cmd_ready = 1'b1;
        host.write_reg(OFS_EVENT_ENABLE, 8'h00);
        v = 8'ha0;
        for (i = 0; i < 5; i++) begin
            @(negedge ref_clk);
            cond[i] = ~cond[i];
            v[i] = 1'b1;
            rd_chk(OFS_EVENT_FLAGS, v);
            check_out("event_irq", 10'(event_irq), 10'h0);
        end
        rd_chk(OFS_EVENT_FLAGS, 8'hbf);
        host.write_reg(OFS_EVENT_CLEAR, 8'h01);
        rd_chk(OFS_EVENT_FLAGS, 8'hbe);
        rd_chk(OFS_EVENT_CLEAR, 8'h00);
        host.write_reg(OFS_EVENT_ENABLE, 8'hbf);
        check_out("event_irq", 10'(event_irq), 10'h1);
        host.write_reg(OFS_EVENT_CLEAR, 8'hff);
        check_out("event_irq", 10'(event_irq), 10'h0);
        rd_chk(OFS_EVENT_FLAGS, 8'h20);
        cmd_ready = 1'b0;
        rd_chk(OFS_EVENT_FLAGS, 8'h00);
        // mid-run reset: defaults return, conditions already high are not toggles but init done flags again
        reset_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        check_out("crop_stop", crop_stop, 10'h000);
        check_out("forced_std", 10'(forced_std), 10'(STD_AUTO));
        reset_n = 1'b1;
        rd_chk(OFS_EVENT_FLAGS, 8'h80);
        repeat (3) @(negedge ref_clk);
        results();
    end

endmodule : tb_video_decoder_control_status_regs

// *** testbench/vdcs_host_model.sv ***
// Purpose: behavioural host processor issuing register accesses to the bank
// Assumes: serial transfers already reduced to one-cycle strobes on ref_clk_i
// Notes:   each call drops its strobe at the falling edge after the taking edge
module vdcs_host_model
    import vdcs_pkg::*;
(
    input  wire logic   ref_clk_i,  // system clock
    output vdcs_req_type req_o      // request towards the bank
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        req_o = '0;
    end

    // request set at a falling edge, taken at the next rising one and dropped
    // at the falling edge after it, so a strobe is never seen twice
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask : write_reg

    // write data is unqualified during a read, so it carries junk
    task automatic read_reg(input logic [7:0] addr);
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~req_o.wdata};
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~req_o.wdata};
    endtask : read_reg

    // released lines show the inverse so stale values never look valid
    task automatic release_bus;
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~req_o.addr, wdata: ~req_o.wdata};
    endtask : release_bus

endmodule : vdcs_host_model
